// ### logic/host_port_controller.sv
// processor end: AXI4-Lite command registers driving the access sequence
`timescale 1ns/100ps
`default_nettype none
module host_port_controller
   import host_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   host_port_if.host link,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_PULSE = 6'b000010,
      H_WAITRDY = 6'b000100,
      H_SELECT = 6'b001000,
      H_STROBE = 6'b010000,
      H_RELEASE = 6'b100000
   } host_state_t;

   host_state_t state;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;
   logic [2:0] pinLevel;
   logic [2:0] next_pinLevel;
   logic irqPrev;
   logic [3:0] count;
   logic opWrite;
   logic keep;
   logic sessionOpen;
   logic [7:0] target;
   logic [31:0] writeData;
   logic [31:0] readData;
   logic requestSeen;
   logic awHeld;
   logic wHeld;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= HOST_SYNC_RESET;
         sync2 <= HOST_SYNC_RESET;
         sync3 <= HOST_SYNC_RESET;
         pinLevel <= HOST_SYNC_RESET;
         irqPrev <= 1'b0;
      end else begin
         sync1 <= {link.waitN, link.ready, link.devIrq};
         sync2 <= sync1;
         sync3 <= sync2;
         pinLevel <= next_pinLevel;
         irqPrev <= pinLevel[0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_filter
         assign next_pinLevel[g] = (sync2[g] == sync3[g]) ? sync2[g] : pinLevel[g];
      end
   endgenerate

   wire waitLow = !pinLevel[2];
   wire readyOn = pinLevel[1];
   wire irqEdge = pinLevel[0] & !irqPrev;

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire wrMapped = (awAddr == OFS_CONTROL) || (awAddr == OFS_TARGET) ||
      (awAddr == OFS_WRITE_DATA) || (awAddr == OFS_READ_DATA) || (awAddr == OFS_STATUS);
   wire goCmd = doWrite && awAddr == OFS_CONTROL && wStrb[0] && wData[CTL_GO];
   wire startOp = goCmd && state == H_IDLE;
   wire clearReq = doWrite && awAddr == OFS_STATUS && wStrb[0] && wData[ST_REQUEST];
   wire [31:0] statusWord = {29'h0, requestSeen, sessionOpen, state != H_IDLE};
   wire [7:0] rdAddr = s_axi_araddr;
   wire rdMapped = (rdAddr == OFS_CONTROL) || (rdAddr == OFS_TARGET) ||
      (rdAddr == OFS_WRITE_DATA) || (rdAddr == OFS_READ_DATA) || (rdAddr == OFS_STATUS);
   wire [31:0] ctlWord = {29'h0, keep, opWrite, 1'b0};
   wire [31:0] rdWord = (rdAddr == OFS_CONTROL) ? ctlWord :
      (rdAddr == OFS_TARGET) ? {24'h000000, target} :
      (rdAddr == OFS_WRITE_DATA) ? writeData :
      (rdAddr == OFS_READ_DATA) ? readData :
      (rdAddr == OFS_STATUS) ? statusWord : 32'h0000_0000;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdWord;
         s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // target and write data are not changed under a running access
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               writeData[8*g+7:8*g] <= 8'h00;
            end else if (doWrite && awAddr == OFS_WRITE_DATA && wStrb[g] && state == H_IDLE) begin
               writeData[8*g+7:8*g] <= wData[8*g+7:8*g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         target <= 8'h00;
         requestSeen <= 1'b0;
      end else begin
         if (doWrite && awAddr == OFS_TARGET && wStrb[0] && state == H_IDLE) begin
            target <= wData[7:0];
         end
         // a new device interrupt wins over a clear
         if (irqEdge) begin
            requestSeen <= 1'b1;
         end else if (clearReq) begin
            requestSeen <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= H_IDLE;
         count <= 4'h0;
         opWrite <= 1'b0;
         keep <= 1'b0;
         sessionOpen <= 1'b0;
         readData <= 32'h0000_0000;
         link.hold <= 1'b0;
         link.sessionStart <= 1'b0;
         link.csN <= 1'b1;
         link.oeN <= 1'b1;
         link.weN <= 1'b1;
         link.addr <= 8'h00;
         link.hostDataOe <= 1'b0;
      end else begin
         unique case (state)
            H_IDLE: if (startOp) begin
               opWrite <= wData[CTL_WRITE];
               keep <= wData[CTL_KEEP];
               link.hold <= wData[CTL_KEEP];
               link.addr <= target;
               if (sessionOpen) begin
                  link.csN <= 1'b0;
                  state <= H_SELECT;
               end else begin
                  count <= PULSE_CYCLES;
                  state <= H_PULSE;
               end
            end
            H_PULSE: begin
               link.sessionStart <= (count != 4'h0);
               count <= (count != 4'h0) ? count - 4'h1 : 4'h0;
               if (count == 4'h0) state <= H_WAITRDY;
            end
            H_WAITRDY: if (readyOn) begin
               sessionOpen <= 1'b1;
               link.csN <= 1'b0;
               state <= H_SELECT;
            end
            H_SELECT: if (waitLow) begin
               link.oeN <= opWrite;
               link.weN <= !opWrite;
               link.hostDataOe <= opWrite;
               state <= H_STROBE;
            end
            H_STROBE: if (!waitLow) begin
               readData <= opWrite ? readData : link.dataBus;
               link.oeN <= 1'b1;
               link.weN <= 1'b1;
               link.hold <= keep;
               count <= GAP_CYCLES;
               state <= H_RELEASE;
            end
            H_RELEASE: begin
               link.csN <= 1'b1;
               link.hostDataOe <= 1'b0;
               sessionOpen <= keep;
               count <= (count != 4'h0) ? count - 4'h1 : 4'h0;
               // gap lets the device filter see select high before the next one
               if (count == 4'h0) state <= H_IDLE;
            end
         endcase
      end
   end

   assign link.hostData = writeData;
endmodule : host_port_controller
`default_nettype wire

// ### logic/host_port_device.sv
// device end: request mailbox, handshake flag and register access sessions
`timescale 1ns/100ps
`default_nettype none
module host_port_device
   import host_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   host_port_if.device link,
   input wire logic postReq,
   input wire logic [31:0] postAddr,
   input wire logic [31:0] postCount,
   input wire logic [31:0] postMoved,
   input wire logic [7:0] postConfig,
   input wire logic [7:0] postInterface,
   input wire logic [7:0] postAlternate,
   input wire logic [31:0] postArgA,
   input wire logic [31:0] postArgB,
   output logic postTaken,
   output logic requestDone,
   output logic [7:0] commandArgument,
   input wire logic fifoLoad,
   input wire logic [31:0] fifoLoadData,
   output logic fifoWritten,
   output logic fifoRead,
   output logic [31:0] fifoWindow,
   output logic inSession
);
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_SCAN = 5'b00010,
      S_STALL = 5'b00100,
      S_LATCH = 5'b01000,
      S_DRIVE = 5'b10000
   } dev_state_t;

   dev_state_t state;
   dev_state_t next_state;
   logic [4:0] pinRaw;
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [4:0] sync3;
   logic [4:0] pinLevel;
   logic [4:0] next_pinLevel;
   logic startPrev;
   logic [31:0] mailbox [0:MAILBOX_N-1];
   logic [7:0] target;
   logic [31:0] devData;
   logic devDataOe;
   logic [3:0] irqCount;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   assign pinRaw = {link.csN, link.oeN, link.weN, link.hold, link.sessionStart};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= DEV_SYNC_RESET;
         sync2 <= DEV_SYNC_RESET;
         sync3 <= DEV_SYNC_RESET;
         pinLevel <= DEV_SYNC_RESET;
         startPrev <= 1'b0;
      end else begin
         sync1 <= pinRaw;
         sync2 <= sync1;
         sync3 <= sync2;
         pinLevel <= next_pinLevel;
         startPrev <= pinLevel[0];
      end
   end

   // a level counts only once two later stages agree
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_filter
         assign next_pinLevel[g] = (sync2[g] == sync3[g]) ? sync2[g] : pinLevel[g];
      end
   endgenerate

   wire selOn = !pinLevel[4];
   wire readOn = !pinLevel[3];
   wire writeOn = !pinLevel[2];
   wire holdOn = pinLevel[1];
   wire startEdge = pinLevel[0] & !startPrev;

   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   wire strobeSeen = (state == S_STALL) && (readOn || writeOn);
   wire hostWrite = strobeSeen && writeOn && !readOn;
   wire hostRead = strobeSeen && readOn;
   wire [31:0] busWord = link.dataBus;
   wire hostSetsDone = hostWrite && (target == IDX_HANDSHAKE) && busWord[DONE_BIT];

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: if (startEdge) next_state = S_SCAN;
         S_SCAN: if (selOn) next_state = S_STALL;
         S_STALL: if (strobeSeen) next_state = S_LATCH;
         S_LATCH: next_state = S_DRIVE;
         S_DRIVE: if (!selOn) next_state = holdOn ? S_SCAN : S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // address is stable by the time select is seen through the filter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         target <= 8'h00;
      end else if (state == S_SCAN && selOn) begin
         target <= link.addr;
      end
   end

   assign link.waitN = !(state == S_STALL || state == S_LATCH);
   assign link.ready = (state != S_IDLE);
   assign inSession = (state != S_IDLE);

   // ---------------------------------------------------------------
   // read selection
   // ---------------------------------------------------------------
   wire inMailbox = (target < IDX_COMMAND);
   wire [31:0] boxWord = mailbox[target[2:0]];
   wire [31:0] cmdWord = {24'h000000, commandArgument};
   wire [31:0] shakeWord = {30'h0, requestDone, 1'b0};
   wire [31:0] readWord = inMailbox ? boxWord :
      (target == IDX_COMMAND) ? cmdWord :
      (target == IDX_HANDSHAKE) ? shakeWord :
      (target == IDX_FIFO) ? fifoWindow : REG_RESET;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         devData <= REG_RESET;
         devDataOe <= 1'b0;
      end else if (hostRead) begin
         devData <= readWord;
         devDataOe <= 1'b1;
      end else if (!readOn || state == S_IDLE || state == S_SCAN) begin
         devDataOe <= 1'b0;
      end
   end

   assign link.devData = devData;
   assign link.devDataOe = devDataOe;

   // ---------------------------------------------------------------
   // mailbox posting and handshake
   // ---------------------------------------------------------------
   // a set from the processor in the same cycle beats the device clear
   assign postTaken = postReq && requestDone && !hostSetsDone;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < MAILBOX_N; i++) begin
            mailbox[i] <= REG_RESET;
         end
      end else if (postTaken) begin
         mailbox[IDX_XFER_ADDR[2:0]] <= postAddr;
         mailbox[IDX_XFER_COUNT[2:0]] <= postCount;
         mailbox[IDX_MOVED[2:0]] <= postMoved;
         mailbox[IDX_CONFIG[2:0]] <= {24'h000000, postConfig};
         mailbox[IDX_INTERFACE[2:0]] <= {24'h000000, postInterface};
         mailbox[IDX_ALTERNATE[2:0]] <= {24'h000000, postAlternate};
         mailbox[IDX_ARG_A[2:0]] <= postArgA;
         mailbox[IDX_ARG_B[2:0]] <= postArgB;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         requestDone <= HANDSHAKE_RESET[DONE_BIT];
      end else if (hostSetsDone) begin
         requestDone <= 1'b1;
      end else if (postTaken) begin
         requestDone <= 1'b0;
      end
   end

   // interrupt starts on the same edge that clears the flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqCount <= 4'h0;
      end else if (postTaken) begin
         irqCount <= PULSE_CYCLES;
      end else if (irqCount != 4'h0) begin
         irqCount <= irqCount - 4'h1;
      end
   end

   // pulse spans several cycles so the far filter cannot miss it
   assign link.devIrq = (irqCount != 4'h0);

   // ---------------------------------------------------------------
   // processor-written registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         commandArgument <= 8'h00;
      end else if (hostWrite && target == IDX_COMMAND) begin
         commandArgument <= busWord[7:0];
      end
   end

   // a processor push wins over a local load in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fifoWindow <= REG_RESET;
         fifoWritten <= 1'b0;
         fifoRead <= 1'b0;
      end else begin
         fifoWritten <= hostWrite && target == IDX_FIFO;
         fifoRead <= hostRead && target == IDX_FIFO;
         if (hostWrite && target == IDX_FIFO) begin
            fifoWindow <= busWord;
         end else if (fifoLoad) begin
            fifoWindow <= fifoLoadData;
         end
      end
   end
endmodule : host_port_device
`default_nettype wire

// ### logic/host_port_if.sv
// pin bundle between the system processor and the device
`timescale 1ns/100ps
`default_nettype none
interface host_port_if;
   logic [7:0] addr;
   logic csN;
   logic oeN;
   logic weN;
   logic hold;
   logic sessionStart;
   logic waitN;
   logic ready;
   logic devIrq;
   logic [31:0] hostData;
   logic hostDataOe;
   logic [31:0] devData;
   logic devDataOe;
   logic [31:0] dataBus;
   // shared data wire, resolved from the two enables
   assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : 32'h0000_0000);
   modport device (input addr, csN, oeN, weN, hold, sessionStart, hostData, hostDataOe, dataBus,
      output waitN, ready, devIrq, devData, devDataOe);
   modport host (output addr, csN, oeN, weN, hold, sessionStart, hostData, hostDataOe,
      input waitN, ready, devIrq, devData, devDataOe, dataBus);
endinterface : host_port_if
`default_nettype wire

// ### logic/host_port_pkg.sv
// constants shared by both ends of the parallel host register port
package host_port_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int FIELD_W = 8;
   // ---------------------------------------------------------------
   // link register indices
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_XFER_ADDR = 8'h00;
   localparam logic [7:0] IDX_XFER_COUNT = 8'h01;
   localparam logic [7:0] IDX_MOVED = 8'h02;
   localparam logic [7:0] IDX_CONFIG = 8'h03;
   localparam logic [7:0] IDX_INTERFACE = 8'h04;
   localparam logic [7:0] IDX_ALTERNATE = 8'h05;
   localparam logic [7:0] IDX_ARG_A = 8'h06;
   localparam logic [7:0] IDX_ARG_B = 8'h07;
   localparam logic [7:0] IDX_COMMAND = 8'h08;
   localparam logic [7:0] IDX_HANDSHAKE = 8'h09;
   localparam logic [7:0] IDX_FIFO = 8'h0A;
   localparam int MAILBOX_N = 8;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [31:0] HANDSHAKE_RESET = 32'h0000_0002;
   localparam int DONE_BIT = 1;
   // ---------------------------------------------------------------
   // pin timing and synchroniser resets
   // ---------------------------------------------------------------
   localparam logic [3:0] PULSE_CYCLES = 4'h4;
   localparam logic [3:0] GAP_CYCLES = 4'h8;
   localparam logic [4:0] DEV_SYNC_RESET = 5'h1C;
   localparam logic [2:0] HOST_SYNC_RESET = 3'h4;
   // ---------------------------------------------------------------
   // controller registers on the AXI4-Lite side
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_TARGET = 8'h04;
   localparam logic [7:0] OFS_WRITE_DATA = 8'h08;
   localparam logic [7:0] OFS_READ_DATA = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int CTL_GO = 0;
   localparam int CTL_WRITE = 1;
   localparam int CTL_KEEP = 2;
   localparam int ST_BUSY = 0;
   localparam int ST_SESSION = 1;
   localparam int ST_REQUEST = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : host_port_pkg

// ### verification/host_port_chk.sv
// pin-level assertions between the processor end and the device end
`timescale 1ns/100ps
`default_nettype none
module host_port_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic csN,
   input wire logic oeN,
   input wire logic hold,
   input wire logic sessionStart,
   input wire logic waitN,
   input wire logic ready,
   input wire logic devIrq,
   input wire logic devDataOe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_wait_in_select: assert property (!waitN |-> !csN && ready)
      else $error("wait low outside a selected session");
   chk_drive_at_release: assert property ($rose(waitN) && !oeN |-> devDataOe)
      else $error("wait released on a read without data driven");
   chk_drive_when_read: assert property ($rose(devDataOe) |-> !oeN && !csN)
      else $error("data driven without select and output enable");
   chk_wait_bounded: assert property ($fell(waitN) |-> ##[1:30] waitN)
      else $error("wait held too long");
   chk_ready_on_start: assert property ($rose(sessionStart) |-> ##[1:12] ready)
      else $error("start pulse did not raise ready");
   chk_idle_no_wait: assert property (!ready |-> waitN)
      else $error("wait asserted outside a session");
   chk_leave_session: assert property ($rose(csN) && !hold |-> ##[1:8] !ready)
      else $error("ready kept after last access");
   chk_stay_session: assert property ($rose(csN) && hold |-> ready [*8])
      else $error("session left while hold high");
   chk_irq_pulse: assert property ($rose(devIrq) |-> devIrq [*4] ##1 !devIrq)
      else $error("interrupt pulse width wrong");
endmodule : host_port_chk
`default_nettype wire

// ### verification/host_request_regs_pio_read_tb_top.sv
// self-checking bench joining both ends of the host register port
`timescale 1ns/100ps
`default_nettype none
module host_request_regs_pio_read_tb_top;
   import host_port_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awAddr = 8'h0, arAddr = 8'h0;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid, postTaken, requestDone;
   logic fifoWritten, fifoRead, inSession;
   logic [1:0] bResp, rResp;
   logic [31:0] wData = 32'h0, rData, fifoWindow, fifoLoadData = 32'h0;
   logic postReq = 1'b0, fifoLoad = 1'b0;
   logic [31:0] postAddr = 32'h0, postCount = 32'h0, postMoved = 32'h0;
   logic [31:0] postArgA = 32'h0, postArgB = 32'h0;
   logic [7:0] postConfig = 8'h0, postInterface = 8'h0, postAlternate = 8'h0, commandArgument;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] fifoWrites = 32'h0, fifoReads = 32'h0;
   always @(negedge clk) begin
      fifoWrites <= fifoWrites + {31'h0, fifoWritten};
      fifoReads <= fifoReads + {31'h0, fifoRead};
   end
   always #5 clk = ~clk;
   host_port_if link ();
   host_port_device i_host_port_device (.clk(clk), .rst_n(rst_n), .link(link),
      .postReq(postReq), .postAddr(postAddr), .postCount(postCount), .postMoved(postMoved),
      .postConfig(postConfig), .postInterface(postInterface), .postAlternate(postAlternate),
      .postArgA(postArgA), .postArgB(postArgB), .postTaken(postTaken),
      .requestDone(requestDone), .commandArgument(commandArgument), .fifoLoad(fifoLoad),
      .fifoLoadData(fifoLoadData), .fifoWritten(fifoWritten), .fifoRead(fifoRead),
      .fifoWindow(fifoWindow), .inSession(inSession));
   host_port_controller i_host_port_controller (.clk(clk), .rst_n(rst_n), .link(link),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
   host_port_chk i_host_port_chk (.clk(clk), .rst_n(rst_n), .csN(link.csN), .oeN(link.oeN),
      .hold(link.hold), .sessionStart(link.sessionStart), .waitN(link.waitN),
      .ready(link.ready), .devIrq(link.devIrq), .devDataOe(link.devDataOe));
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // handshake flags sampled mid-cycle, so the coming edge decides without a race
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge clk);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(negedge clk);
         ta = awReady;
         tw = wReady;
         tb = bValid;
         r = bResp;
         @(posedge clk);
         if (ta) awValid <= 1'b0;
         if (tw) wValid <= 1'b0;
      end while (!tb);
      bReady <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
      logic ta, tr;
      @(posedge clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(negedge clk);
         ta = arReady;
         tr = rValid;
         q = rData;
         r = rResp;
         @(posedge clk);
         if (ta) arValid <= 1'b0;
      end while (!tr);
      rReady <= 1'b0;
   endtask : axr
   task automatic lnk(input logic [7:0] idx, input logic wr, input logic keep,
      input logic [31:0] d, output logic [31:0] q);
      logic [1:0] r;
      logic [31:0] s;
      axw(OFS_TARGET, {24'h0, idx}, r);
      axw(OFS_WRITE_DATA, d, r);
      axw(OFS_CONTROL, {29'h0, keep, wr, 1'b1}, r);
      s = 32'h1;
      for (int i = 0; i < 100 && s[ST_BUSY] !== 1'b0; i++) axr(OFS_STATUS, s, r);
      chk({31'h0, s[ST_BUSY]}, 32'h0);
      axr(OFS_READ_DATA, q, r);
   endtask : lnk
   function automatic logic [31:0] expect_reg(input int idx);
      case (idx)
         0: return postAddr;
         1: return postCount;
         2: return postMoved;
         3: return {24'h0, postConfig};
         4: return {24'h0, postInterface};
         5: return {24'h0, postAlternate};
         6: return postArgA;
         7: return postArgB;
         9: return 32'h0;
         default: return 32'h0;
      endcase
   endfunction : expect_reg
   initial begin
      #500000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      logic [31:0] q, d;
      logic [1:0] r;
      void'($urandom(32'hC64A899B));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i <= 10; i++) begin
         lnk(i[7:0], 1'b0, i < 10, 32'h0, q);
         chk(q, i == 9 ? HANDSHAKE_RESET : expect_reg(i));
      end
      chk({30'h0, inSession, link.ready}, 32'h0);
      for (int n = 0; n < 3; n++) begin
         @(posedge clk);
         {postAddr, postCount, postMoved, postArgA} <=
            {$urandom(), $urandom(), $urandom(), $urandom()};
         {postArgB, postConfig, postInterface, postAlternate} <= {$urandom(), 24'($urandom())};
         postReq <= 1'b1;
         // done flag still clear from the last request: nothing may be taken
         repeat (n > 0 ? 20 : 0) begin
            @(negedge clk);
            chk({30'h0, postTaken, link.devIrq}, 32'h0);
         end
         if (n > 0) lnk(IDX_HANDSHAKE, 1'b1, 1'b0, 32'h2, q);
         for (int k = 0; k < 50 && postTaken !== 1'b1; k++) @(negedge clk);
         @(posedge clk);
         postReq <= 1'b0;
         @(negedge clk);
         chk({31'h0, requestDone}, 32'h0);
         for (int i = 0; i <= 9; i++) begin
            lnk(i[7:0], 1'b0, 1'b1, 32'h0, q);
            if (i != 8) chk(q, expect_reg(i));
         end
      end
      // upper bits kept at zero by the processor side
      lnk(IDX_COMMAND, 1'b1, 1'b1, 32'h0000_005A, q);
      chk({24'h0, commandArgument}, 32'h5A);
      lnk(IDX_COMMAND, 1'b0, 1'b1, 32'h0, q);
      chk(q, 32'h5A);
      lnk(8'h20, 1'b0, 1'b1, 32'h0, q);
      chk(q, 32'h0);
      d = $urandom();
      lnk(IDX_FIFO, 1'b1, 1'b1, d, q);
      chk(fifoWindow, d);
      @(posedge clk);
      fifoLoad <= 1'b1;
      fifoLoadData <= ~d;
      @(posedge clk);
      fifoLoad <= 1'b0;
      lnk(IDX_FIFO, 1'b0, 1'b0, 32'h0, q);
      chk(q, ~d);
      chk(fifoWrites, 32'h1);
      chk(fifoReads, 32'h2);
      axr(OFS_STATUS, q, r);
      chk(q, 32'h1 << ST_REQUEST);
      axw(OFS_STATUS, 32'h1 << ST_REQUEST, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      axr(OFS_STATUS, q, r);
      chk(q, 32'h0);
      axw(8'h40, 32'h1, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      axr(8'h40, q, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      tally_and_finish();
   end
endmodule : host_request_regs_pio_read_tb_top
`default_nettype wire
